// ===== logic/set_reset_latch_unit.v
`timescale 1ns/10ps
`include "sr_latch_consts.vh"

// ****************************************************************
// Set/reset latch unit with Avalon-MM register slave
// ****************************************************************
module set_reset_latch_unit #(
    parameter CNT_W = `DIV_CNT_W          // Divider counter width
) (
    ref_clk,
    resetn,
    address,
    read,
    write,
    writedata,
    byteenable,
    readdata,
    waitrequest,
    comp1_output,
    comp2_output,
    latch_input_pin,
    true_output_pin,
    true_output_pin_oe,
    inverted_output_pin,
    inverted_output_pin_oe,
    latch_q,
    latch_nq
);
    input  wire        ref_clk;           // 200 MHz system clock
    input  wire        resetn;            // Async reset, active low
    input  wire [3:0]  address;           // Byte address
    input  wire        read;              // Avalon read
    input  wire        write;             // Avalon write
    input  wire [31:0] writedata;         // Write data
    input  wire [3:0]  byteenable;        // Byte lanes
    output reg  [31:0] readdata;          // Read data
    output reg         waitrequest;       // Stall until answered
    input  wire        comp1_output;      // Comparator 1 result
    input  wire        comp2_output;      // Comparator 2 result
    input  wire        latch_input_pin;   // External latch input
    output reg         true_output_pin;   // True output to pin
    output reg         true_output_pin_oe;     // Drive enable
    output reg         inverted_output_pin;    // Inverted to pin
    output reg         inverted_output_pin_oe; // Drive enable
    output reg         latch_q;           // Internal true output
    output reg         latch_nq;          // Internal inverted output

    // ************************************************************
    // Registers and internal state
    // ************************************************************
    reg  [7:0]       control_q;           // Stored control bits
    reg  [7:0]       source_q;            // Source enable bits
    reg              fw_set_q;            // One-cycle firmware set
    reg              fw_reset_q;          // One-cycle firmware reset
    reg  [CNT_W-1:0] div_cnt_q;           // Free running divider
    reg              div_pulse_q;         // Divided clock pulse
    reg              state_q;             // The latch itself
    reg              state_d;             // Next latch value
    reg  [CNT_W-1:0] div_mask;            // Low bits that must be ones
    reg  [31:0]      rd_value;            // Decoded read value
    wire             req;                 // Any bus request
    wire             accept;              // Request answered this edge
    wire             wr_ok;               // Write lane zero accepted
    wire             latch_on;            // Latch enabled
    wire [2:0]       div_sel;             // Divider select code
    wire             set_in;              // Effective set input
    wire             reset_in;            // Effective reset input

    assign req      = read | write;
    assign accept   = req & ~waitrequest;
    assign wr_ok    = write & accept & byteenable[0];
    assign latch_on = control_q[`CTL_LATCH_ON];
    assign div_sel  = control_q[`CTL_DIV_HI:`CTL_DIV_LO];

    // ************************************************************
    // Bus handshake
    // ************************************************************
    // Waitrequest drops for one cycle, one cycle after a request
    // shows up; the request completes at the edge where it is low.
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            waitrequest <= 1'b1;
        end else if (req && waitrequest) begin
            waitrequest <= 1'b0;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    // Read decode; unmapped offsets read as zero
    always @* begin
        rd_value = 32'h0000_0000;
        case (address)
            `OFS_LATCH_CONTROL: begin
                // Pulse bits are never stored, so they read zero
                rd_value[7:0] = control_q;
            end
            `OFS_SOURCE_ENABLE: begin
                rd_value[7:0] = source_q;
            end
            `OFS_LATCH_STATUS: begin
                rd_value[1:0] = {~state_q, state_q};
            end
            default: begin
                rd_value = 32'h0000_0000;
            end
        endcase
    end

    // Read data is loaded while waitrequest is still high, so it
    // already stands when the master samples waitrequest low.
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            readdata <= 32'h0000_0000;
        end else if (read && waitrequest) begin
            readdata <= rd_value;
        end
    end

    // ************************************************************
    // Control and source enable registers
    // ************************************************************
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            control_q <= `CTL_RESET_VAL;
            source_q  <= `SRC_RESET_VAL;
        end else if (wr_ok) begin
            if (address == `OFS_LATCH_CONTROL) begin
                control_q <= writedata[7:0] & `CTL_STORE_MASK;
            end
            if (address == `OFS_SOURCE_ENABLE) begin
                source_q <= writedata[7:0];
            end
        end
    end

    // ************************************************************
    // Firmware pulses
    // ************************************************************
    // A write of one yields exactly one cycle of pulse and clears
    // itself; a write of zero does nothing.
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fw_set_q   <= 1'b0;
            fw_reset_q <= 1'b0;
        end else begin
            fw_set_q   <= wr_ok && (address == `OFS_LATCH_CONTROL)
                          && writedata[`CTL_FW_SET];
            fw_reset_q <= wr_ok && (address == `OFS_LATCH_CONTROL)
                          && writedata[`CTL_FW_RESET];
        end
    end

    // ************************************************************
    // Pulse divider
    // ************************************************************
    // Mask of the low counter bits: select 0 keeps 2 bits (every
    // 4th cycle), select 7 keeps 9 bits (every 512th cycle).
    always @* begin
        div_mask = {CNT_W{1'b0}};
        case (div_sel)
            3'h0:    div_mask = 9'h003;
            3'h1:    div_mask = 9'h007;
            3'h2:    div_mask = 9'h00f;
            3'h3:    div_mask = 9'h01f;
            3'h4:    div_mask = 9'h03f;
            3'h5:    div_mask = 9'h07f;
            3'h6:    div_mask = 9'h0ff;
            3'h7:    div_mask = 9'h1ff;
            default: div_mask = 9'h003;
        endcase
    end

    // Counter runs free so a select change takes effect at once
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt_q   <= {CNT_W{1'b0}};
            div_pulse_q <= 1'b0;
        end else begin
            div_cnt_q   <= div_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            // One cycle wide pulse on each wrap of the masked bits
            div_pulse_q <= ((div_cnt_q & div_mask) == div_mask);
        end
    end

    // ************************************************************
    // Effective set and reset inputs
    // ************************************************************
    // Every source acts on its high level when its enable is set; the firmware pulses need no enable.
    assign set_in =
          (source_q[`SRC_PIN_SET] & latch_input_pin)
        | (source_q[`SRC_CLK_SET] & div_pulse_q)
        | (source_q[`SRC_C2_SET]  & comp2_output)
        | (source_q[`SRC_C1_SET]  & comp1_output)
        | fw_set_q;
    assign reset_in =
          (source_q[`SRC_PIN_RESET] & latch_input_pin)
        | (source_q[`SRC_CLK_RESET] & div_pulse_q)
        | (source_q[`SRC_C2_RESET]  & comp2_output)
        | (source_q[`SRC_C1_RESET]  & comp1_output)
        | fw_reset_q;

    // ************************************************************
    // The latch
    // ************************************************************
    // Reset dominates; with neither input high the state holds.
    always @* begin
        state_d = state_q;
        if (reset_in) begin
            state_d = 1'b0;
        end else if (set_in) begin
            state_d = 1'b1;
        end
    end

    // Deliberately outside the reset: firmware must put the latch
    // in a known state before steering it onto the pins. Until
    // then the state, and the internal outputs, are unknown.
    always @(posedge ref_clk) begin
        state_q  <= state_d;
        latch_q  <= state_d;
        latch_nq <= ~state_d;
    end

    // ************************************************************
    // Pin outputs
    // ************************************************************
    // Pin enables only matter while the latch is on; each output
    // has its own enable so both may drive pins at once. The
    // port's own direction bit is outside this block.
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            true_output_pin        <= 1'b0;
            true_output_pin_oe     <= 1'b0;
            inverted_output_pin    <= 1'b0;
            inverted_output_pin_oe <= 1'b0;
        end else begin
            true_output_pin_oe     <= latch_on
                & control_q[`CTL_TRUE_PIN_EN];
            inverted_output_pin_oe <= latch_on
                & control_q[`CTL_INV_PIN_EN];
            true_output_pin        <= latch_on
                & control_q[`CTL_TRUE_PIN_EN] & state_d;
            inverted_output_pin    <= latch_on
                & control_q[`CTL_INV_PIN_EN] & ~state_d;
        end
    end

endmodule

// ===== logic/sr_latch_consts.vh
`ifndef SR_LATCH_CONSTS_VH
`define SR_LATCH_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_LATCH_CONTROL   4'h0
`define OFS_SOURCE_ENABLE   4'h4
`define OFS_LATCH_STATUS    4'h8

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTL_LATCH_ON        7
`define CTL_DIV_HI          6
`define CTL_DIV_LO          4
`define CTL_TRUE_PIN_EN     3
`define CTL_INV_PIN_EN      2
`define CTL_FW_SET          1
`define CTL_FW_RESET        0
`define CTL_RESET_VAL       8'h00
// Writable bits that are stored; pulse bits are never stored
`define CTL_STORE_MASK      8'hfc

// ****************************************************************
// Source enable register fields
// ****************************************************************
`define SRC_PIN_SET         7
`define SRC_CLK_SET         6
`define SRC_C2_SET          5
`define SRC_C1_SET          4
`define SRC_PIN_RESET       3
`define SRC_CLK_RESET       2
`define SRC_C2_RESET        1
`define SRC_C1_RESET        0
`define SRC_RESET_VAL       8'h00

// ****************************************************************
// Divider
// ****************************************************************
// Smallest divide is 4, i.e. select code plus two low counter bits
`define DIV_BASE_SHIFT      2
`define DIV_CNT_W           9

`endif

// ===== dv/sr_latch_checks_asserts.sv
`timescale 1ns/10ps
// ********************
// Latch unit checker
// ********************
module sr_latch_checks (
    input wire        ref_clk,
    input wire        resetn,
    input wire [3:0]  address,
    input wire        read,
    input wire        write,
    input wire [31:0] writedata,
    input wire [3:0]  byteenable,
    input wire [31:0] readdata,
    input wire        waitrequest,
    input wire        comp1_output,
    input wire        comp2_output,
    input wire        latch_input_pin,
    input wire        true_output_pin,
    input wire        true_output_pin_oe,
    input wire        inverted_output_pin,
    input wire        inverted_output_pin_oe,
    input wire        latch_q,
    input wire        latch_nq
);
    reg  [7:0] src_q;    // Mirror of the source enable register
    wire       set_any;  // Some enabled comparator or pin set source is high
    wire       rst_any;  // Some enabled comparator or pin reset source is high
    wire       clk_en;   // Divider steers the latch; hides source timing
    // Mirror follows accepted writes only
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            src_q <= 8'h00;
        else if (write && !waitrequest && address == 4'h4 && byteenable[0])
            src_q <= writedata[7:0];
    end
    assign set_any = comp1_output & src_q[4] | comp2_output & src_q[5] |
                     latch_input_pin & src_q[7];
    assign rst_any = comp1_output & src_q[0] | comp2_output & src_q[1] |
                     latch_input_pin & src_q[3];
    assign clk_en  = src_q[6] | src_q[2];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    answer_bound_a: assert property ((read || write) && waitrequest
        |-> ##[1:2] !waitrequest) else $error("bus answer late");
    wait_single_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    pulse_reads_zero_a: assert property (
        read && !waitrequest && address == 4'h0 |-> readdata[1:0] == 2'b00)
        else $error("pulse bits read nonzero");
    upper_zero_a: assert property (read && !waitrequest
        |-> readdata[31:8] == 24'h0) else $error("upper bits nonzero");
    true_pin_off_a: assert property (
        !true_output_pin_oe |-> !true_output_pin) else $error("true pin");
    inv_pin_off_a: assert property (
        !inverted_output_pin_oe |-> !inverted_output_pin)
        else $error("inverted pin");
    outputs_inverse_a: assert property (
        $changed(latch_q) |-> latch_nq == !latch_q) else $error("nq");
    reset_wins_a: assert property (
        rst_any |=> !latch_q) else $error("reset source ignored");
    source_set_a: assert property (
        set_any && !rst_any && !clk_en && !$past(write) |=> latch_q)
        else $error("set source ignored");
    cover property (set_any && rst_any);
    cover property (write && !waitrequest && address == 4'h4);
    cover property ($fell(latch_q) && clk_en);
endmodule
bind set_reset_latch_unit sr_latch_checks i_chk (.*);

// ===== dv/source_model.sv
`timescale 1ns/10ps
// ********************
// Comparators and input pin
// ********************
module source_model (
    input  wire       ref_clk,         // System clock
    input  wire [2:0] drive,           // Levels asked for by the bench
    output reg        comp1_output,    // Comparator 1 level
    output reg        comp2_output,    // Comparator 2 level
    output reg        latch_input_pin  // External pin level
);
    initial {latch_input_pin, comp2_output, comp1_output} = 3'h0;
    // Synchronous levels, active high, held until told otherwise
    always @(posedge ref_clk) begin
        {latch_input_pin, comp2_output, comp1_output} <= drive;
    end
endmodule

// ===== dv/set_reset_latch_unit_bench.sv
`timescale 1ns/10ps
module set_reset_latch_unit_bench;
    logic        ref_clk = 1'b0;     // 200 MHz
    logic        resetn = 1'b0;      // Active low
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [3:0]  address = 4'h0;
    logic [3:0]  byteenable = 4'h0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, q;        // q holds the last read
    logic        waitrequest, latch_q, latch_nq;
    logic        true_output_pin, true_output_pin_oe;
    logic        inverted_output_pin, inverted_output_pin_oe;
    wire         comp1_output, comp2_output, latch_input_pin;
    logic [2:0]  drive = 3'h0;       // Source levels for the model
    logic [7:0]  sb, rb;             // Set and reset enable masks
    logic [3:0]  e;                  // Expected pin outputs
    integer      failures = 0, check_count = 0, m, k, p;
    always #2.5 ref_clk = ~ref_clk;
    set_reset_latch_unit i_dut (.*);
    source_model i_src (.*);
    // ********************
    // Tasks
    // ********************
    task check(input string nm, input [31:0] x, input [31:0] got);
        check_count++;
        if (got !== x) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, x, got);
        end
    endtask
    // Waitrequest is looked at right after each rising edge, before
    // the design updates it, so the value seen is the sampled one
    task bus(input w, input [3:0] a, input [7:0] d, input [3:0] be);
        integer n;
        @(posedge ref_clk);
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= be;
        write <= w;
        read <= !w;
        n = 0;
        @(posedge ref_clk);
        while (waitrequest !== 1'b0 && n < 50) begin
            n++;
            @(posedge ref_clk);
        end
        if (n >= 50)
            failures++;
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task rd(input string nm, input [3:0] a, input [31:0] x);
        bus(1'b0, a, 8'h00, 4'h1);
        check(nm, x, q);
    endtask
    task wr(input [3:0] a, input [7:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask
    task cyc(input integer c);
        repeat (c) @(posedge ref_clk);
    endtask
    task pulse(input integer i);
        @(posedge ref_clk);
        drive[i] <= 1'b1;
        cyc(3);
        drive[i] <= 1'b0;
        cyc(3);
    endtask
    task wlow;
        integer n;
        n = 0;
        @(negedge ref_clk);
        while (latch_q !== 1'b0 && n < 2000) begin
            n++;
            @(negedge ref_clk);
        end
        if (n >= 2000)
            failures++;
    endtask
    task close_out;
        $display("Checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #200000;
        failures++;
        close_out;
    end
    // ********************
    // Tests
    // ********************
    initial begin
        cyc(8);
        resetn <= 1'b1;
        rd("control", 4'h0, 32'h0);
        rd("source", 4'h4, 32'h0);
        rd("unmapped", 4'hc, 32'h0);
        wr(4'h0, 8'h02);
        rd("fw set", 4'h8, 32'h1);
        rd("pulse bits", 4'h0, 32'h0);
        bus(1'b1, 4'h0, 8'hff, 4'h0);   // Lane off, must be ignored
        rd("lane off", 4'h0, 32'h0);
        wr(4'h0, 8'hff);
        rd("stored", 4'h0, 32'hfc);
        rd("both fw", 4'h8, 32'h2);
        // State, enable and both pin enables in every combination
        for (k = 0; k < 16; k++) begin
            wr(4'h0, {k[2], 3'h0, k[1], k[0], k[3], !k[3]});
            cyc(3);
            e = {k[2] & k[1], k[2] & k[1] & k[3], k[2] & k[0],
                 k[2] & k[0] & !k[3]};
            check("pins", e, {true_output_pin_oe, true_output_pin,
                inverted_output_pin_oe, inverted_output_pin});
        end
        // Each comparator and the pin: set, disabled, reset, and both at once
        for (m = 0; m < 3; m++) begin
            rb = 8'h01 << (m + m / 2);
            sb = rb << 4;
            wr(4'h0, 8'h01);
            wr(4'h4, sb);
            pulse(m);
            check("set src", 1, latch_q);
            wr(4'h4, 8'h00);
            pulse(m);
            check("off src", 1, latch_q);
            wr(4'h4, rb);
            pulse(m);
            check("rst src", 0, latch_q);
            wr(4'h0, 8'h02);
            wr(4'h4, sb | rb);
            pulse(m);
            check("both src", 0, latch_q);
        end
        wr(4'h4, 8'h01);
        wr(4'h0, 8'h02);
        pulse(0);
        check("self clear", 0, latch_q);
        // Divider pulses reset against a held set source
        wr(4'h4, 8'h14);
        drive[0] <= 1'b1;
        for (k = 0; k < 8; k++) begin
            wr(4'h0, {1'b0, k[2:0], 4'h0});
            wlow;
            wlow;
            @(negedge ref_clk);
            check("width", 1, latch_q);
            p = 1;
            while (latch_q !== 1'b0 && p < 2000) begin
                @(negedge ref_clk);
                p++;
            end
            check("period", 32'd4 << k, p);
        end
        cyc(1);
        drive <= 3'h0;
        wr(4'h0, 8'h01);
        cyc(2);
        check("clk pre", 0, latch_q);
        wr(4'h4, 8'h40);
        cyc(8);
        check("clk set", 1, latch_q);
        wr(4'h4, 8'h00);
        wr(4'h0, 8'h02);
        cyc(2);
        resetn <= 1'b0;
        cyc(3);
        resetn <= 1'b1;
        check("held", 1, latch_q);
        check("held nq", 0, latch_nq);
        rd("ctl reset", 4'h0, 32'h0);
        rd("status held", 4'h8, 32'h1);
        close_out;
    end
endmodule
